// file: hw/aclme_match_rule_engine.sv
`timescale 1ns/1ps
// Notes on behaviour
// - layer select 00 never matches
// - layer select picks l2, l3 or l4
// - l2 sub 01 compares ethertype only
// - l2 sub 10 mac only, 11 both
// - l2 sub 00 is count mode
// - side bit: 0 destination, 1 source
// - polarity: 0 unequal true, 1 equal
// - count value from action priority fields
// - time base: 0 microsecond, 1 millisecond
// - algorithm 0: watchdog down-counter, expiry event
// - algorithm 1: packet counter, terminal event
// - l3 sub 01 masked, 10 exact
// - mask bit 1 excludes address bit
// - exact: address is source, mask destination
// - l4 sub: protocol, tcp, udp, sequence
// - protocol byte against stored value
// - range op: off, either, inside, outside
// - port bounds, joined form sequence number
// - flag enable turns flag matching on
// - flag ignore bit 1 excludes flag
// - count mode pairs match and action
// - count events reported per port
module aclme_match_rule_engine #(
	parameter int NPORTS = 6
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire aclme_pkg::aclme_pkt_t pkt,
	output aclme_pkg::aclme_verdict_t verdict,
	output logic [NPORTS-1:0] countStatus,
	output logic countIrq
);

	// configuration registers
	logic [31:0] ctrl;
	logic [31:0] macLo;
	logic [31:0] macHi;
	logic [31:0] ipAddr;
	logic [31:0] ipv4_dont_care_bits;
	logic [31:0] ports;
	logic [31:0] flags;
	logic [31:0] action;
	logic [NPORTS-1:0] intStatus;
	logic [NPORTS-1:0] intMask;

	// decoded control fields
	logic [1:0] layer_select;
	logic [1:0] sub_select;
	logic addrSide;
	logic match_polarity;
	logic [1:0] port_range_op;
	logic tcp_flag_enable;
	logic [7:0] ip_next_header_value;
	logic [47:0] ruleMac;
	logic [15:0] ruleType;
	logic [15:0] minPort;
	logic [15:0] maxPort;
	logic [7:0] ruleFlags;
	logic [7:0] tcp_flag_ignore_bits;
	logic [aclme_pkg::COUNT_W-1:0] countValue;
	logic time_base;
	logic count_algorithm;
	logic countMode;

	// bus strobes
	logic wrStrobe;
	logic rdSetup;
	logic addrKnown;

	// count engine state
	logic [aclme_pkg::COUNT_W-1:0] counter;
	logic running;
	logic [2:0] lastPort;
	logic [6:0] usPrescale;
	logic [9:0] msPrescale;
	logic usTick;
	logic unitTick;
	logic [NPORTS-1:0] eventSet;
	logic [NPORTS-1:0] statusClr;

	// match intermediates
	logic l2Hit;
	logic l3Hit;
	logic l4Hit;
	logic ruleHit;
	logic qualifying;

	assign layer_select = ctrl[aclme_pkg::CTRL_LAYER_LSB +: 2];
	assign sub_select = ctrl[aclme_pkg::CTRL_SUB_LSB +: 2];
	assign addrSide = ctrl[aclme_pkg::CTRL_SIDE_BIT];
	assign match_polarity = ctrl[aclme_pkg::CTRL_POL_BIT];
	assign port_range_op = ctrl[aclme_pkg::CTRL_RANGE_LSB +: 2];
	assign tcp_flag_enable = ctrl[aclme_pkg::CTRL_FLAGEN_BIT];
	assign ip_next_header_value = ctrl[aclme_pkg::CTRL_PROTO_LSB +: 8];
	assign ruleMac = {macHi[15:0], macLo};
	assign ruleType = macHi[31:16];
	assign minPort = ports[15:0];
	assign maxPort = ports[31:16];
	assign ruleFlags = flags[7:0];
	assign tcp_flag_ignore_bits = flags[15:8];
	// priority policy, priority, remark bits and map merge, in that order
	assign countValue = action[aclme_pkg::ACT_COUNT_LSB +: 11];
	assign time_base = action[aclme_pkg::ACT_TIMEBASE_BIT];
	assign count_algorithm = action[aclme_pkg::ACT_ALGO_BIT];
	// count mode is layer 2 with sub select 00
	assign countMode = (layer_select == aclme_pkg::LAYER_L2) &&
		(sub_select == 2'b00);

	// apb handshake: zero wait states, access phase always ready
	assign pready = psel && penable;
	assign wrStrobe = psel && penable && pwrite;
	assign rdSetup = psel && !penable && !pwrite;

	// address decode for the error path; the read path decodes paddr on its own
	always_comb
	begin
		unique case (paddr)
			aclme_pkg::OFS_CTRL, aclme_pkg::OFS_MAC_LO,
			aclme_pkg::OFS_MAC_HI, aclme_pkg::OFS_IP_ADDR,
			aclme_pkg::OFS_IPV4_DONT_CARE_BITS, aclme_pkg::OFS_PORTS,
			aclme_pkg::OFS_FLAGS, aclme_pkg::OFS_ACTION,
			aclme_pkg::OFS_INT_STATUS, aclme_pkg::OFS_INT_MASK,
			aclme_pkg::OFS_COUNT_STATE:
				addrKnown = 1'b1;
			default:
				addrKnown = 1'b0; // unmapped word
		endcase
	end

	// unmapped addresses answer with an error in the access phase
	assign pslverr = psel && penable && !addrKnown;

	// configuration writes land at the access-phase edge
	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			ctrl <= aclme_pkg::REG_RESET;
			macLo <= aclme_pkg::REG_RESET;
			macHi <= aclme_pkg::REG_RESET;
			ipAddr <= aclme_pkg::REG_RESET;
			ipv4_dont_care_bits <= aclme_pkg::REG_RESET;
			ports <= aclme_pkg::REG_RESET;
			flags <= aclme_pkg::REG_RESET;
			action <= aclme_pkg::REG_RESET;
			intMask <= aclme_pkg::REG_RESET[NPORTS-1:0];
		end
		else if (wrStrobe)
		begin
			unique case (paddr)
				aclme_pkg::OFS_CTRL:
					ctrl <= pwdata;
				aclme_pkg::OFS_MAC_LO:
					macLo <= pwdata;
				aclme_pkg::OFS_MAC_HI:
					macHi <= pwdata;
				aclme_pkg::OFS_IP_ADDR:
					ipAddr <= pwdata;
				aclme_pkg::OFS_IPV4_DONT_CARE_BITS:
					ipv4_dont_care_bits <= pwdata;
				aclme_pkg::OFS_PORTS:
					ports <= pwdata;
				aclme_pkg::OFS_FLAGS:
					flags <= pwdata;
				aclme_pkg::OFS_ACTION:
					action <= pwdata;
				aclme_pkg::OFS_INT_MASK:
					intMask <= pwdata[NPORTS-1:0];
				default:
				begin
					// status is write-one-to-clear, others ignore writes
				end
			endcase
		end
	end

	// read data captured in the setup phase so prdata comes from a flop
	always_ff @(posedge clock)
	begin
		if (!reset_n)
			prdata <= aclme_pkg::REG_RESET;
		else if (rdSetup)
		begin
			unique case (paddr)
				aclme_pkg::OFS_CTRL:
					prdata <= ctrl;
				aclme_pkg::OFS_MAC_LO:
					prdata <= macLo;
				aclme_pkg::OFS_MAC_HI:
					prdata <= macHi;
				aclme_pkg::OFS_IP_ADDR:
					prdata <= ipAddr;
				aclme_pkg::OFS_IPV4_DONT_CARE_BITS:
					prdata <= ipv4_dont_care_bits;
				aclme_pkg::OFS_PORTS:
					prdata <= ports;
				aclme_pkg::OFS_FLAGS:
					prdata <= flags;
				aclme_pkg::OFS_ACTION:
					prdata <= action;
				aclme_pkg::OFS_INT_STATUS:
					prdata <= 32'(intStatus);
				aclme_pkg::OFS_INT_MASK:
					prdata <= 32'(intMask);
				aclme_pkg::OFS_COUNT_STATE:
					prdata <= {8'h00, 5'h00, lastPort, 4'h0,
						running, counter};
				default:
					prdata <= 32'h00000000; // unmapped reads as zero
			endcase
		end
	end

	// layer 2 compare: mac, ethertype or both
	always_comb
	begin
		logic [47:0] mac;
		logic macEq;
		logic typeEq;
		logic eq;
		eq = 1'b0; // settled by the sub select below
		mac = addrSide ? pkt.srcMac : pkt.dstMac;
		macEq = (mac == ruleMac);
		typeEq = (pkt.etherType == ruleType);
		unique case (sub_select)
			2'b01:
				eq = typeEq;
			2'b10:
				eq = macEq;
			default:
				eq = macEq && typeEq; // 11 and count mode
		endcase
		l2Hit = match_polarity ? eq : !eq;
	end

	// layer 3 compare: masked single address or exact pair
	always_comb
	begin
		logic [31:0] ip;
		logic eq;
		logic legal;
		ip = addrSide ? pkt.srcIp : pkt.dstIp;
		eq = 1'b0;
		legal = 1'b0;
		unique case (sub_select)
			2'b01:
			begin
				// mask bit set means do not compare
				eq = ((ip ^ ipAddr) & ~ipv4_dont_care_bits) == 32'h0;
				legal = 1'b1;
			end
			2'b10:
			begin
				// mask word doubles as the expected destination
				eq = (pkt.srcIp == ipAddr) &&
					(pkt.dstIp == ipv4_dont_care_bits);
				legal = 1'b1;
			end
			default:
			begin
				// reserved codes never match, whatever the polarity
				eq = 1'b0;
				legal = 1'b0;
			end
		endcase
		l3Hit = legal && pkt.isIpv4 &&
			(match_polarity ? eq : !eq);
	end

	// layer 4 compare: protocol, ports, sequence, tcp flags
	always_comb
	begin
		logic [15:0] port;
		logic portOk;
		logic flagOk;
		logic eq;
		logic present;
		// defaults first, so no path can leave a latch behind
		portOk = 1'b0;
		eq = 1'b0;
		present = 1'b0;
		port = addrSide ? pkt.srcPort : pkt.dstPort;
		unique case (port_range_op)
			2'b00:
				portOk = 1'b1; // port test off, other terms decide
			2'b01:
				portOk = (port == maxPort) || (port == minPort);
			2'b10:
				portOk = (port >= minPort) && (port <= maxPort);
			2'b11:
				portOk = (port < minPort) || (port > maxPort);
		endcase
		flagOk = !tcp_flag_enable ||
			(((pkt.tcpFlags ^ ruleFlags) & ~tcp_flag_ignore_bits) ==
			8'h00);
		unique case (sub_select)
			2'b00:
			begin
				eq = (pkt.ipProto == ip_next_header_value);
				present = pkt.isIpv4;
			end
			2'b01:
			begin
				eq = portOk && flagOk;
				present = pkt.isIpv4 && pkt.isTcp;
			end
			2'b10:
			begin
				// udp carries no flags, so only the port test applies
				eq = portOk;
				present = pkt.isIpv4 && pkt.isUdp;
			end
			2'b11:
			begin
				// max bound is the upper half of the sequence number
				eq = (pkt.tcpSeq == {maxPort, minPort}) && flagOk;
				present = pkt.isIpv4 && pkt.isTcp;
			end
		endcase
		l4Hit = present && (match_polarity ? eq : !eq);
	end

	// layer select chooses which compare drives the verdict
	always_comb
	begin
		unique case (aclme_pkg::aclme_layer_t'(layer_select))
			aclme_pkg::LAYER_OFF:
				ruleHit = 1'b0;
			aclme_pkg::LAYER_L2:
				ruleHit = l2Hit;
			aclme_pkg::LAYER_L3:
				ruleHit = l3Hit;
			aclme_pkg::LAYER_L4:
				ruleHit = l4Hit;
		endcase
	end

	// a packet that feeds the count engine
	assign qualifying = pkt.valid && countMode && l2Hit;

	// verdict one cycle after the header, count mode never forwards
	always_ff @(posedge clock)
	begin
		if (!reset_n)
			verdict <= '0;
		else
		begin
			verdict.valid <= pkt.valid;
			verdict.hit <= pkt.valid && ruleHit && !countMode;
			verdict.port <= pkt.port;
		end
	end

	// microsecond prescaler, restarted by a reload so periods are whole
	always_ff @(posedge clock)
	begin
		if (!reset_n)
			usPrescale <= '0;
		else if (qualifying || usTick)
			usPrescale <= '0;
		else
			usPrescale <= usPrescale + 7'h01;
	end
	assign usTick = (usPrescale == 7'(aclme_pkg::CYCLES_PER_US - 1));

	// millisecond prescaler counts microsecond ticks
	always_ff @(posedge clock)
	begin
		if (!reset_n)
			msPrescale <= '0;
		else if (qualifying)
			msPrescale <= '0;
		else if (usTick)
		begin
			if (msPrescale == 10'(aclme_pkg::MILLISECOND_US - 1))
				msPrescale <= '0;
			else
				msPrescale <= msPrescale + 10'h001;
		end
	end

	// time base picks the unit the watchdog counts in
	assign unitTick = usTick && (!time_base ||
		(msPrescale == 10'(aclme_pkg::MILLISECOND_US - 1)));

	// count engine: watchdog or packet counter on the action entry
	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			counter <= '0;
			running <= 1'b0;
			lastPort <= 3'h0;
			eventSet <= '0;
		end
		else
		begin
			eventSet <= '0;
			if (!countMode)
			begin
				// leaving count mode drops any armed watchdog
				counter <= '0;
				running <= 1'b0;
			end
			else if (!count_algorithm)
			begin
				// match and action of the same entry act together
				if (qualifying)
				begin
					counter <= countValue;
					running <= 1'b1;
					lastPort <= pkt.port;
				end
				else if (running && unitTick)
				begin
					if (counter <= 11'h001)
					begin
						counter <= '0;
						running <= 1'b0;
						eventSet[lastPort] <= 1'b1;
					end
					else
						counter <= counter - 11'h001;
				end
			end
			else
			begin
				// time base plays no part in the packet counter
				running <= 1'b0;
				if (qualifying)
				begin
					lastPort <= pkt.port;
					if (counter + 11'h001 >= countValue)
					begin
						counter <= '0;
						eventSet[pkt.port] <= 1'b1;
					end
					else
						counter <= counter + 11'h001;
				end
			end
		end
	end

	// write-one-to-clear request against the status word
	assign statusClr = (wrStrobe && paddr == aclme_pkg::OFS_INT_STATUS) ?
		pwdata[NPORTS-1:0] : '0;

	// per-port sticky status, a new event beats a clear in one cycle
	always_ff @(posedge clock)
	begin
		if (!reset_n)
			intStatus <= '0;
		else
			intStatus <= (intStatus & ~statusClr) | eventSet;
	end

	// per-port status and the masked summary request
	assign countStatus = intStatus;
	always_ff @(posedge clock)
	begin
		if (!reset_n)
			countIrq <= 1'b0;
		else
			countIrq <= |(((intStatus & ~statusClr) | eventSet) &
				intMask);
	end

endmodule : aclme_match_rule_engine

// file: inc/aclme_pkg.sv
// shared constants and carriers for the acl match rule engine
package aclme_pkg;

	// register byte offsets on the apb side
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_MAC_LO = 8'h04;
	localparam logic [7:0] OFS_MAC_HI = 8'h08;
	localparam logic [7:0] OFS_IP_ADDR = 8'h0c;
	localparam logic [7:0] OFS_IPV4_DONT_CARE_BITS = 8'h10;
	localparam logic [7:0] OFS_PORTS = 8'h14;
	localparam logic [7:0] OFS_FLAGS = 8'h18;
	localparam logic [7:0] OFS_ACTION = 8'h1c;
	localparam logic [7:0] OFS_INT_STATUS = 8'h20;
	localparam logic [7:0] OFS_INT_MASK = 8'h24;
	localparam logic [7:0] OFS_COUNT_STATE = 8'h28;

	// field positions in the control word
	localparam int CTRL_LAYER_LSB = 0;
	localparam int CTRL_SUB_LSB = 2;
	localparam int CTRL_SIDE_BIT = 4;
	localparam int CTRL_POL_BIT = 5;
	localparam int CTRL_RANGE_LSB = 6;
	localparam int CTRL_FLAGEN_BIT = 8;
	localparam int CTRL_PROTO_LSB = 16;

	// field positions in the action word (count mode view)
	localparam int ACT_COUNT_LSB = 0;
	localparam int ACT_TIMEBASE_BIT = 11;
	localparam int ACT_ALGO_BIT = 12;
	localparam int COUNT_W = 11;

	// reset value of every register
	localparam logic [31:0] REG_RESET = 32'h00000000;

	// layer select codes
	typedef enum logic [1:0] {
		LAYER_OFF = 2'b00,
		LAYER_L2 = 2'b01,
		LAYER_L3 = 2'b10,
		LAYER_L4 = 2'b11
	} aclme_layer_t;

	// timing: tick units and clock rate
	localparam int CLOCK_PERIOD_NS = 10;
	localparam int MICROSECOND_NS = 1000;
	localparam int MILLISECOND_US = 1000;
	localparam int CYCLES_PER_US = MICROSECOND_NS / CLOCK_PERIOD_NS;

	// header fields handed over by the ingress parser
	typedef struct packed {
		logic valid;
		logic [2:0] port;
		logic [47:0] dstMac;
		logic [47:0] srcMac;
		logic [15:0] etherType;
		logic isIpv4;
		logic [31:0] srcIp;
		logic [31:0] dstIp;
		logic [7:0] ipProto;
		logic isTcp;
		logic isUdp;
		logic [15:0] srcPort;
		logic [15:0] dstPort;
		logic [31:0] tcpSeq;
		logic [7:0] tcpFlags;
	} aclme_pkt_t;

	// verdict returned to the forwarding logic
	typedef struct packed {
		logic valid;
		logic hit;
		logic [2:0] port;
	} aclme_verdict_t;

endpackage : aclme_pkg

// file: sim/aclme_match_rule_engine_sva.sv
`timescale 1ns/1ps
module aclme_match_rule_engine_sva #(
	parameter int NPORTS = 6
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire aclme_pkg::aclme_pkt_t pkt,
	input wire aclme_pkg::aclme_verdict_t verdict,
	input wire logic [NPORTS-1:0] countStatus,
	input wire logic countIrq
);
	logic [31:0] ctrl; // shadow of the control word
	logic wrDone; // write lands at this edge
	logic clrWr; // status clear lands at this edge
	assign wrDone = psel && penable && pwrite && pready;
	assign clrWr = wrDone && paddr == aclme_pkg::OFS_INT_STATUS;
	// mirror control writes, the checker cannot see the register itself
	always_ff @(posedge clock)
	begin
		if (!reset_n)
			ctrl <= 32'h00000000;
		else if (wrDone && paddr == aclme_pkg::OFS_CTRL)
			ctrl <= pwdata;
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	AST_VERDICT_LAT: assert property (pkt.valid |=> verdict.valid)
		else $error("verdict missing after packet");
	AST_VERDICT_PORT: assert property (pkt.valid |=> verdict.port == $past(pkt.port))
		else $error("verdict port differs from packet port");
	AST_VERDICT_IDLE: assert property (!pkt.valid |=> !verdict.valid)
		else $error("verdict without packet");
	AST_DISABLED: assert property (pkt.valid && ctrl[1:0] == 2'h0 |=> !verdict.hit)
		else $error("disabled rule produced a hit");
	AST_COUNT_NOHIT: assert property (pkt.valid && ctrl[3:0] == 4'h1 |=> !verdict.hit)
		else $error("count mode produced a hit");
	AST_NO_HEADER: assert property (pkt.valid && !pkt.isIpv4 && ctrl[1] |=> !verdict.hit)
		else $error("hit on packet without ip header");
	AST_STICKY: assert property (!clrWr |=> ($past(countStatus) & ~countStatus) == '0)
		else $error("count status dropped without clear");
	// irq loads the masked form of the next value that status loads, so it never stands without status
	AST_IRQ_QUIET: assert property (countStatus == '0 |-> !countIrq)
		else $error("interrupt without status");
	AST_PREADY: assert property (psel |-> pready == penable)
		else $error("ready outside access phase");
	AST_UNMAPPED: assert property (psel && penable && paddr > 8'h28 |-> pslverr)
		else $error("unmapped access not refused");
	// main scenarios reached
	COV_HIT: cover property (pkt.valid ##1 verdict.hit);
	COV_IRQ: cover property ($rose(countIrq));
	COV_ERR: cover property (psel && penable && pslverr);
endmodule : aclme_match_rule_engine_sva

bind aclme_match_rule_engine aclme_match_rule_engine_sva #(.NPORTS(NPORTS)) u_sva (
	.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .pkt(pkt), .verdict(verdict),
	.countStatus(countStatus), .countIrq(countIrq));

// file: sim/aclme_parser_model.sv
`timescale 1ns/1ps
// stand-in for the ingress parser; no rule binds this side
module aclme_parser_model (
	input wire logic clock,
	output aclme_pkg::aclme_pkt_t pkt
);
	aclme_pkg::aclme_pkt_t idle; // released header fields
	initial pkt = '0;
	// one-cycle valid, then fields are scrambled so stale data never
	// passes for live data
	task automatic send(input aclme_pkg::aclme_pkt_t p);
		idle = ~p;
		idle.valid = 1'b0;
		@(posedge clock);
		pkt <= p;
		@(posedge clock);
		pkt <= idle;
	endtask : send
endmodule : aclme_parser_model

// file: sim/aclme_match_rule_engine_test.sv
`timescale 1ns/1ps
module aclme_match_rule_engine_test;
	logic clock = 1'b0;
	logic reset_n = 1'b0; // held low through the first cycles
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	aclme_pkg::aclme_pkt_t pkt; // from the parser model
	aclme_pkg::aclme_verdict_t verdict;
	logic [5:0] countStatus;
	logic countIrq;
	int num_errors = 0;
	int compares = 0;
	aclme_pkg::aclme_pkt_t base; // reference tcp packet
	aclme_pkg::aclme_pkt_t noIp; // same packet, no ip header
	always #5 clock = ~clock;
	aclme_match_rule_engine #(.NPORTS(6)) u_dut (.clock(clock),
		.reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pkt(pkt), .verdict(verdict),
		.countStatus(countStatus), .countIrq(countIrq));
	aclme_parser_model u_parser (.clock(clock), .pkt(pkt));
	// value compare
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			num_errors++;
			$display("MISMATCH %0t value %h expected %h", $time, got, exp);
		end
	endtask : check
	// verdict compare, port included
	task automatic checkHit(input aclme_pkg::aclme_verdict_t exp);
		compares++;
		if (verdict !== exp)
		begin
			num_errors++;
			$display("MISMATCH %0t verdict %h expected %h", $time, verdict, exp);
		end
	endtask : checkHit
	// one apb transfer; waits on pready, never assumes a latency
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		int n;
		n = 0;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1 && n < 50)
		begin
			@(posedge clock);
			n++;
		end
		q = prdata;
		e = pslverr;
		if (n >= 50)
		begin
			num_errors++;
			$display("MISMATCH %0t no ready from slave", $time);
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask : wr
	task automatic rdChk(input logic [7:0] a, input logic [31:0] exp,
		input logic expErr);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h00000000, q, e);
		check(q, exp);
		check(e, expErr);
	endtask : rdChk
	// packet in, verdict checked one cycle later
	task automatic sendChk(input aclme_pkg::aclme_pkt_t p, input logic exp);
		u_parser.send(p);
		#1;
		checkHit({1'b1, exp, p.port});
	endtask : sendChk
	task automatic tryRule(input logic [31:0] c, input aclme_pkg::aclme_pkt_t p,
		input logic exp);
		wr(aclme_pkg::OFS_CTRL, c);
		sendChk(p, exp);
	endtask : tryRule
	// control word: layer, sub, side, polarity, range op, flag enable
	function automatic logic [31:0] cw(input logic [1:0] lay, sub,
		input logic side, pol, input logic [1:0] op, input logic fe);
		cw = {16'h0006, 7'h00, fe, op, pol, side, sub, lay};
	endfunction : cw
	task automatic wrap_up;
		if (num_errors == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : wrap_up
	// watchdog, far beyond the few hundred cycles the tests need
	initial
	begin
		repeat (20000) @(posedge clock);
		num_errors++;
		wrap_up;
	end
	initial
	begin
		base = {1'b1, 3'd3, 48'h0a0b0c0d0e0f, 48'h112233445566, 16'h0800,
			1'b1, 32'hc0a80001, 32'h0a000005, 8'h06, 1'b1, 1'b0, 16'h0050,
			16'h1f90, 32'h12345678, 8'h12};
		noIp = base;
		noIp.isIpv4 = 1'b0;
		noIp.isTcp = 1'b0;
		repeat (12) @(posedge clock);
		reset_n <= 1'b1;
		rdChk(aclme_pkg::OFS_CTRL, 32'h0, 1'b0);
		rdChk(8'h2c, 32'h0, 1'b1);
		wr(aclme_pkg::OFS_COUNT_STATE, 32'hffffffff);
		rdChk(aclme_pkg::OFS_COUNT_STATE, 32'h0, 1'b0);
		sendChk(base, 1'b0);
		// layer 2: destination mac matches, ethertype does not
		wr(aclme_pkg::OFS_MAC_LO, 32'h0c0d0e0f);
		wr(aclme_pkg::OFS_MAC_HI, 32'h86dd0a0b);
		tryRule(cw(1, 1, 0, 1, 0, 0), base, 1'b0);
		tryRule(cw(1, 1, 0, 0, 0, 0), base, 1'b1);
		tryRule(cw(1, 2, 0, 1, 0, 0), base, 1'b1);
		tryRule(cw(1, 2, 1, 1, 0, 0), base, 1'b0);
		tryRule(cw(1, 3, 0, 1, 0, 0), base, 1'b0);
		// layer 3, masked then exact
		wr(aclme_pkg::OFS_IP_ADDR, 32'hc0a800ff);
		wr(aclme_pkg::OFS_IPV4_DONT_CARE_BITS, 32'h000000ff);
		tryRule(cw(2, 1, 1, 1, 0, 0), base, 1'b1);
		tryRule(cw(2, 1, 0, 1, 0, 0), base, 1'b0);
		tryRule(cw(2, 0, 1, 1, 0, 0), base, 1'b0);
		wr(aclme_pkg::OFS_IP_ADDR, 32'hc0a80001);
		wr(aclme_pkg::OFS_IPV4_DONT_CARE_BITS, 32'h0a000005);
		tryRule(cw(2, 2, 0, 1, 0, 0), base, 1'b1);
		tryRule(cw(2, 2, 0, 1, 0, 0), noIp, 1'b0);
		// layer 4: destination port sits on the upper bound
		wr(aclme_pkg::OFS_PORTS, 32'h1f901f40);
		for (int op = 0; op < 4; op++)
			tryRule(cw(3, 1, 0, 1, op[1:0], 0), base, op != 3);
		tryRule(cw(3, 1, 1, 1, 2, 0), base, 1'b0);
		tryRule(cw(3, 2, 0, 1, 1, 0), base, 1'b0);
		tryRule(cw(3, 0, 0, 1, 0, 0), base, 1'b1);
		tryRule(cw(3, 0, 0, 1, 0, 0) ^ 32'h00170000, base, 1'b0);
		wr(aclme_pkg::OFS_FLAGS, 32'h00001002);
		tryRule(cw(3, 1, 0, 1, 1, 1), base, 1'b1);
		wr(aclme_pkg::OFS_FLAGS, 32'h00000002);
		tryRule(cw(3, 1, 0, 1, 1, 1), base, 1'b0);
		wr(aclme_pkg::OFS_PORTS, 32'h12345678);
		tryRule(cw(3, 3, 0, 1, 0, 0), base, 1'b1);
		// packet counter, terminal count of three on port 2
		wr(aclme_pkg::OFS_MAC_HI, 32'h08000a0b);
		wr(aclme_pkg::OFS_ACTION, 32'h00001003);
		wr(aclme_pkg::OFS_INT_MASK, 32'h00000004);
		base.port = 3'd2;
		tryRule(cw(1, 0, 0, 1, 0, 0), base, 1'b0);
		sendChk(base, 1'b0);
		repeat (3) @(posedge clock);
		check(countStatus, 32'h0);
		sendChk(base, 1'b0);
		repeat (3) @(posedge clock);
		check(countStatus, 32'h4);
		check(countIrq, 32'h1);
		wr(aclme_pkg::OFS_INT_STATUS, 32'h00000004);
		rdChk(aclme_pkg::OFS_INT_STATUS, 32'h0, 1'b0);
		check(countIrq, 32'h0);
		// watchdog of two microseconds on port 5
		wr(aclme_pkg::OFS_ACTION, 32'h00000002);
		base.port = 3'd5;
		sendChk(base, 1'b0);
		repeat (150) @(posedge clock);
		check(countStatus, 32'h0);
		// a second packet before expiry must re-arm the watchdog
		sendChk(base, 1'b0);
		repeat (150) @(posedge clock);
		check(countStatus, 32'h0);
		repeat (100) @(posedge clock);
		check(countStatus, 32'h20);
		check(countIrq, 32'h0);
		rdChk(aclme_pkg::OFS_COUNT_STATE, 32'h00050000, 1'b0);
		wrap_up;
	end
endmodule : aclme_match_rule_engine_test
